// file: rtl/pdu_pkg.sv
// constants and types of the peripheral dma unit
// Functional notes
// RL1: each direction has current and next pointer/count
// RL2: four pointer/count sets serve half-duplex use
// RL3: half-duplex software programs one direction at once
// RL4: counters readable anytime, showing transfers left
// RL5: separate on/off commands, enabled state readable
// RL6: pointer advances by 1, 2 or 4
// RL7: rewritten pointer takes effect without stopping
// RL8: count hits zero, next zero: stop, flag
// RL9: nonzero next set moves to current, cleared
// RL10: rx end flag at zero, cleared by write
// RL11: tx end flag at zero, cleared by write
// RL12: rx full flag when both rx counts zero
// RL13: tx empty flag when both tx counts zero
// RL14: rx ready: request bus, read holding, store
// RL15: tx ready: request bus, fetch, load holding
// RL16: peripheral itself raises end-of-transfer interrupt; the unit raises its own irq from pdu_irq instead
// RL17: flags go to served peripheral status
// RL18: zero count halts, nonzero runs if enabled
// RL19: rx full cleared by nonzero rx count write
package pdu_pkg;
    localparam logic [11:0] RX_CUR_PTR_OFF = 12'h100;
    localparam logic [11:0] RX_CUR_CNT_OFF = 12'h104;
    localparam logic [11:0] TX_CUR_PTR_OFF = 12'h108;
    localparam logic [11:0] TX_CUR_CNT_OFF = 12'h10c;
    localparam logic [11:0] RX_NXT_PTR_OFF = 12'h110;
    localparam logic [11:0] RX_NXT_CNT_OFF = 12'h114;
    localparam logic [11:0] TX_NXT_PTR_OFF = 12'h118;
    localparam logic [11:0] TX_NXT_CNT_OFF = 12'h11c;
    localparam logic [11:0] CTRL_OFF = 12'h120;
    localparam logic [11:0] STAT_OFF = 12'h124;
    localparam logic [11:0] IRQ_STAT_OFF = 12'h128;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h12c;
    localparam logic [11:0] CONFIG_OFF = 12'h130;
    localparam int RX_ON_BIT = 0;
    localparam int RX_OFF_BIT = 1;
    localparam int TX_ON_BIT = 8;
    localparam int TX_OFF_BIT = 9;
    localparam int RX_EN_BIT = 0;
    localparam int TX_EN_BIT = 8;
    localparam int EV_COUNT = 4;
    localparam int EV_RX_END = 0;
    localparam int EV_TX_END = 1;
    localparam int EV_RX_FULL = 2;
    localparam int EV_TX_EMPTY = 3;
    localparam logic [31:0] PTR_RESET = 32'h0000_0000;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_HALF = 2'b01,
        SIZE_WORD = 2'b10
    } pdu_size_type;
    localparam pdu_size_type SIZE_RESET = SIZE_BYTE;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RX_REQ = 2'b01,
        ST_RX_WR = 2'b10,
        ST_TX_RD = 2'b11
    } pdu_state_type;
endpackage

// file: rtl/pdu_set_if.sv
// carrier between the engine and one pointer/count set
`timescale 1ns/1ns
interface pdu_set_if;
    logic wr_cur_ptr;
    logic wr_cur_cnt;
    logic wr_nxt_ptr;
    logic wr_nxt_cnt;
    logic [31:0] wdata;
    logic step;
    logic [2:0] step_inc;
    logic [31:0] cur_ptr;
    logic [15:0] cur_cnt;
    logic [31:0] nxt_ptr;
    logic [15:0] nxt_cnt;
    logic end_flag;
    logic buf_flag;
    logic end_ev;
    logic buf_ev;
    modport engine (output wr_cur_ptr, wr_cur_cnt, wr_nxt_ptr, wr_nxt_cnt, wdata, step, step_inc,
        input cur_ptr, cur_cnt, nxt_ptr, nxt_cnt, end_flag, buf_flag, end_ev, buf_ev);
    modport set (input wr_cur_ptr, wr_cur_cnt, wr_nxt_ptr, wr_nxt_cnt, wdata, step, step_inc,
        output cur_ptr, cur_cnt, nxt_ptr, nxt_cnt, end_flag, buf_flag, end_ev, buf_ev);
endinterface

// file: rtl/pdu_chan_set.sv
// one current/next pointer and count set with chaining and flags
`timescale 1ns/1ns
module pdu_chan_set (
    input wire logic clk,
    input wire logic reset_n,
    pdu_set_if.set s
);
    import pdu_pkg::*;
    typedef struct packed {
        logic [31:0] cur_ptr;
        logic [15:0] cur_cnt;
        logic [31:0] nxt_ptr;
        logic [15:0] nxt_cnt;
        logic end_flag;
        logic buf_flag;
        logic end_ev;
        logic buf_ev;
    } pdu_set_state_type;
    pdu_set_state_type r;
    pdu_set_state_type next_r;
    logic sw_wr;
    logic end_ev_low;
    assign sw_wr = s.wr_cur_ptr || s.wr_cur_cnt || s.wr_nxt_ptr || s.wr_nxt_cnt;
    assign end_ev_low = !r.end_ev;
    always_comb begin
        next_r = r;
        next_r.end_ev = 1'b0;
        next_r.buf_ev = 1'b0;
        if (s.step) begin
            next_r.cur_ptr = r.cur_ptr + 32'(s.step_inc); // see RL6
            next_r.cur_cnt = r.cur_cnt - 16'h0001; // see RL8
            if (r.cur_cnt == 16'h0001) begin
                next_r.end_ev = 1'b1;
                if (r.nxt_cnt != CNT_RESET) begin
                    next_r.cur_ptr = r.nxt_ptr; // see RL9
                    next_r.cur_cnt = r.nxt_cnt;
                    next_r.nxt_ptr = PTR_RESET;
                    next_r.nxt_cnt = CNT_RESET;
                end else begin
                    next_r.buf_ev = 1'b1; // see RL8
                end
            end
        end
        if (s.wr_cur_ptr) next_r.cur_ptr = s.wdata; // see RL7
        if (s.wr_cur_cnt) next_r.cur_cnt = s.wdata[15:0]; // see RL1
        if (s.wr_nxt_ptr) next_r.nxt_ptr = s.wdata;
        if (s.wr_nxt_cnt) next_r.nxt_cnt = s.wdata[15:0];
        if ((s.wr_cur_cnt || s.wr_nxt_cnt) && s.wdata[15:0] != CNT_RESET) begin
            next_r.end_flag = 1'b0; // see RL10
            next_r.buf_flag = 1'b0; // see RL19
        end
        if (next_r.end_ev) next_r.end_flag = 1'b1;
        if (next_r.buf_ev) next_r.buf_flag = 1'b1;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) r <= '0;
        else r <= next_r;
    end
    assign s.cur_ptr = r.cur_ptr;
    assign s.cur_cnt = r.cur_cnt;
    assign s.nxt_ptr = r.nxt_ptr;
    assign s.nxt_cnt = r.nxt_cnt;
    assign s.end_flag = r.end_flag;
    assign s.buf_flag = r.buf_flag;
    assign s.end_ev = r.end_ev;
    assign s.buf_ev = r.buf_ev;
    chain_copy_a: assert property ( // see RL9
        @(posedge clk) disable iff (!reset_n)
        s.step && !sw_wr && r.cur_cnt == 16'h0001 && r.nxt_cnt != 16'h0000
        |=> r.cur_cnt == $past(r.nxt_cnt) && r.nxt_cnt == 16'h0000 && r.nxt_ptr == 32'h0)
        else $error("next set not moved into current");
    ptr_step_a: assert property ( // see RL6
        @(posedge clk) disable iff (!reset_n)
        s.step && !sw_wr && r.cur_cnt > 16'h0001
        |=> r.cur_ptr == $past(r.cur_ptr) + 32'($past(s.step_inc)) && end_ev_low)
        else $error("pointer did not advance by item size");
endmodule

// file: rtl/pdu_irq.sv
// sticky event status, mask and one level interrupt
`timescale 1ns/1ns
module pdu_irq (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [pdu_pkg::EV_COUNT-1:0] ev,
    input wire logic clr_wr,
    input wire logic mask_wr,
    input wire logic [pdu_pkg::EV_COUNT-1:0] wdata,
    output logic [pdu_pkg::EV_COUNT-1:0] status,
    output logic [pdu_pkg::EV_COUNT-1:0] mask,
    output logic irq
);
    import pdu_pkg::*;
    typedef struct packed {
        logic [EV_COUNT-1:0] status;
        logic [EV_COUNT-1:0] mask;
        logic irq;
    } pdu_irq_state_type;
    pdu_irq_state_type r;
    pdu_irq_state_type next_r;
    always_comb begin
        next_r = r;
        if (clr_wr) next_r.status = r.status & ~wdata;
        next_r.status = next_r.status | ev;
        if (mask_wr) next_r.mask = wdata;
        next_r.irq = |(next_r.status & next_r.mask);
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) r <= '0;
        else r <= next_r;
    end
    assign status = r.status;
    assign mask = r.mask;
    assign irq = r.irq;
endmodule

// file: rtl/pdu_top.sv
// peripheral dma unit: apb registers, transfer engine, flags
`timescale 1ns/1ns
module pdu_top (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_ready,
    input wire logic [31:0] rx_holding_reg,
    output logic rx_holding_read,
    input wire logic tx_ready,
    output logic [31:0] tx_holding_reg,
    output logic tx_holding_load,
    output logic rx_end_flag,
    output logic tx_end_flag,
    output logic rx_buffers_full_flag,
    output logic tx_buffers_empty_flag,
    output logic rx_channel_enabled,
    output logic tx_channel_enabled,
    output logic bus_req,
    input wire logic bus_gnt,
    output logic [31:0] bus_addr,
    output logic bus_write,
    output pdu_pkg::pdu_size_type bus_size,
    output logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ack,
    output logic irq
);
    import pdu_pkg::*;

    typedef struct packed {
        pdu_state_type state;
        logic rx_en;
        logic tx_en;
        pdu_size_type size;
        logic bus_req;
        logic bus_write;
        logic [31:0] bus_addr;
        logic [31:0] bus_wdata;
        logic rx_hold_rd;
        logic tx_load;
        logic [31:0] tx_data;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pdu_top_state_type;

    pdu_top_state_type r;
    pdu_top_state_type next_r;

    pdu_set_if rx_set ();
    pdu_set_if tx_set ();

    logic setup;
    logic wr_en;
    logic ctrl_wr;
    logic rx_step;
    logic tx_step;
    logic [2:0] item_inc;
    logic [EV_COUNT-1:0] events;
    logic [EV_COUNT-1:0] irq_status;
    logic [EV_COUNT-1:0] irq_mask;
    logic [31:0] rd_data;
    logic rd_hit;

    // apb: one setup cycle, then an access phase of exactly one cycle
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && r.pready;
    assign ctrl_wr = wr_en && paddr == CTRL_OFF;

    // item size to pointer step
    always_comb begin
        unique case (r.size)
            SIZE_BYTE: item_inc = 3'h1; // see RL6
            SIZE_HALF: item_inc = 3'h2;
            SIZE_WORD: item_inc = 3'h4;
            default: item_inc = 3'h1;
        endcase
    end

    assign rx_step = r.state == ST_RX_WR && bus_ack;
    assign tx_step = r.state == ST_TX_RD && bus_ack;

    assign rx_set.wr_cur_ptr = wr_en && paddr == RX_CUR_PTR_OFF;
    assign rx_set.wr_cur_cnt = wr_en && paddr == RX_CUR_CNT_OFF;
    assign rx_set.wr_nxt_ptr = wr_en && paddr == RX_NXT_PTR_OFF;
    assign rx_set.wr_nxt_cnt = wr_en && paddr == RX_NXT_CNT_OFF;
    assign rx_set.wdata = pwdata;
    assign rx_set.step = rx_step;
    assign rx_set.step_inc = item_inc;

    assign tx_set.wr_cur_ptr = wr_en && paddr == TX_CUR_PTR_OFF;
    assign tx_set.wr_cur_cnt = wr_en && paddr == TX_CUR_CNT_OFF;
    assign tx_set.wr_nxt_ptr = wr_en && paddr == TX_NXT_PTR_OFF;
    assign tx_set.wr_nxt_cnt = wr_en && paddr == TX_NXT_CNT_OFF;
    assign tx_set.wdata = pwdata;
    assign tx_set.step = tx_step;
    assign tx_set.step_inc = item_inc;

    // rx and tx sets together are the four sets of a half-duplex channel
    pdu_chan_set rx_chan ( // see RL2
        .clk(clk),
        .reset_n(reset_n),
        .s(rx_set.set)
    );

    pdu_chan_set tx_chan ( // see RL1
        .clk(clk),
        .reset_n(reset_n),
        .s(tx_set.set)
    );

    assign events[EV_RX_END] = rx_set.end_ev;
    assign events[EV_TX_END] = tx_set.end_ev; // see RL11
    assign events[EV_RX_FULL] = rx_set.buf_ev; // see RL12
    assign events[EV_TX_EMPTY] = tx_set.buf_ev; // see RL13

    pdu_irq irq_unit (
        .clk(clk),
        .reset_n(reset_n),
        .ev(events),
        .clr_wr(wr_en && paddr == IRQ_STAT_OFF),
        .mask_wr(wr_en && paddr == IRQ_MASK_OFF),
        .wdata(pwdata[EV_COUNT-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // read mux; counters show the transfers still left
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            RX_CUR_PTR_OFF: rd_data = rx_set.cur_ptr;
            RX_CUR_CNT_OFF: rd_data = {16'h0000, rx_set.cur_cnt}; // see RL4
            TX_CUR_PTR_OFF: rd_data = tx_set.cur_ptr;
            TX_CUR_CNT_OFF: rd_data = {16'h0000, tx_set.cur_cnt}; // see RL4
            RX_NXT_PTR_OFF: rd_data = rx_set.nxt_ptr;
            RX_NXT_CNT_OFF: rd_data = {16'h0000, rx_set.nxt_cnt};
            TX_NXT_PTR_OFF: rd_data = tx_set.nxt_ptr;
            TX_NXT_CNT_OFF: rd_data = {16'h0000, tx_set.nxt_cnt};
            CTRL_OFF: rd_data = 32'h0000_0000;
            STAT_OFF: begin
                rd_data[RX_EN_BIT] = r.rx_en; // see RL5
                rd_data[TX_EN_BIT] = r.tx_en;
            end
            IRQ_STAT_OFF: rd_data = {28'h000_0000, irq_status};
            IRQ_MASK_OFF: rd_data = {28'h000_0000, irq_mask};
            CONFIG_OFF: rd_data = {30'h0000_0000, r.size};
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.rx_hold_rd = 1'b0;
        next_r.tx_load = 1'b0;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        if (setup) begin
            next_r.pready = 1'b1;
            next_r.prdata = pwrite ? 32'h0000_0000 : rd_data;
            next_r.pslverr = !rd_hit;
        end
        // off beats on when both are written together
        if (ctrl_wr && pwdata[RX_ON_BIT]) next_r.rx_en = 1'b1; // see RL5
        if (ctrl_wr && pwdata[RX_OFF_BIT]) next_r.rx_en = 1'b0;
        if (ctrl_wr && pwdata[TX_ON_BIT]) next_r.tx_en = 1'b1;
        if (ctrl_wr && pwdata[TX_OFF_BIT]) next_r.tx_en = 1'b0;
        if (wr_en && paddr == CONFIG_OFF) begin
            unique case (pwdata[1:0])
                2'b00: next_r.size = SIZE_BYTE;
                2'b01: next_r.size = SIZE_HALF;
                default: next_r.size = SIZE_WORD;
            endcase
        end
        unique case (r.state)
            ST_IDLE: begin
                // zero count halts that direction; rx served first
                if (r.rx_en && rx_ready && rx_set.cur_cnt != CNT_RESET) begin // see RL18
                    next_r.bus_req = 1'b1; // see RL14
                    next_r.bus_write = 1'b1;
                    next_r.bus_addr = rx_set.cur_ptr;
                    next_r.state = ST_RX_REQ;
                end else if (r.tx_en && tx_ready && tx_set.cur_cnt != CNT_RESET) begin
                    next_r.bus_req = 1'b1; // see RL15
                    next_r.bus_write = 1'b0;
                    next_r.bus_addr = tx_set.cur_ptr;
                    next_r.state = ST_TX_RD;
                end
            end
            ST_RX_REQ: begin
                if (bus_gnt) begin
                    next_r.rx_hold_rd = 1'b1; // see RL14
                    next_r.bus_wdata = rx_holding_reg;
                    next_r.state = ST_RX_WR;
                end
            end
            ST_RX_WR: begin
                if (bus_ack) begin
                    next_r.bus_req = 1'b0;
                    next_r.bus_write = 1'b0;
                    next_r.state = ST_IDLE;
                end
            end
            ST_TX_RD: begin
                if (bus_ack) begin
                    next_r.bus_req = 1'b0;
                    next_r.tx_data = bus_rdata; // see RL15
                    next_r.tx_load = 1'b1;
                    next_r.state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
            r.size <= SIZE_RESET;
            r.state <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign rx_holding_read = r.rx_hold_rd;
    assign tx_holding_reg = r.tx_data;
    assign tx_holding_load = r.tx_load;
    // flags are handed to the served peripheral's status
    assign rx_end_flag = rx_set.end_flag; // see RL17
    assign tx_end_flag = tx_set.end_flag;
    assign rx_buffers_full_flag = rx_set.buf_flag;
    assign tx_buffers_empty_flag = tx_set.buf_flag;
    assign rx_channel_enabled = r.rx_en;
    assign tx_channel_enabled = r.tx_en;
    assign bus_req = r.bus_req;
    assign bus_addr = r.bus_addr;
    assign bus_write = r.bus_write;
    assign bus_size = r.size;
    assign bus_wdata = r.bus_wdata;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence rx_granted;
        r.state == ST_RX_REQ && bus_gnt;
    endsequence

    sequence rx_stored;
        r.state == ST_RX_WR && bus_ack;
    endsequence

    sequence rx_last_stored;
        rx_stored ##0 rx_set.cur_cnt == 16'h0001;
    endsequence

    sequence sw_idle;
        !wr_en;
    endsequence

    cnt_read_a: assert property ( // see RL4
        setup && !pwrite && paddr == RX_CUR_CNT_OFF && !rx_step
        |=> prdata == {16'h0000, $past(rx_set.cur_cnt)} && pready)
        else $error("rx count read shows wrong value");

    chan_on_a: assert property ( // see RL5
        ctrl_wr && pwdata[TX_ON_BIT] && !pwdata[TX_OFF_BIT]
        |=> tx_channel_enabled ##1 tx_channel_enabled || $past(ctrl_wr))
        else $error("tx direction not enabled by command");

    chan_off_a: assert property ( // see RL5
        ctrl_wr && pwdata[RX_OFF_BIT]
        |=> !rx_channel_enabled)
        else $error("rx direction not disabled by command");

    ptr_rewrite_a: assert property ( // see RL7
        wr_en && paddr == TX_CUR_PTR_OFF && !tx_step
        |=> tx_set.cur_ptr == $past(pwdata))
        else $error("rewritten pointer not taken");

    zero_halt_a: assert property ( // see RL18
        r.state == ST_IDLE && rx_set.cur_cnt == 16'h0000 && tx_set.cur_cnt == 16'h0000
        |=> !bus_req)
        else $error("bus requested with both counts zero");

    rx_order_a: assert property ( // see RL14
        rx_granted
        |=> rx_holding_read && bus_req && bus_write
        && bus_wdata == $past(rx_holding_reg) ##1 !rx_holding_read)
        else $error("rx holding read not after grant");

    rx_end_a: assert property ( // see RL10
        rx_last_stored ##0 sw_idle
        |=> rx_end_flag && !bus_req)
        else $error("rx end flag not set at zero count");

    rx_full_a: assert property ( // see RL12
        rx_last_stored ##0 sw_idle ##0 rx_set.nxt_cnt == 16'h0000
        |=> rx_buffers_full_flag && rx_set.cur_cnt == 16'h0000)
        else $error("rx full flag not set with both counts zero");

    rx_clear_a: assert property ( // see RL19
        wr_en && paddr == RX_NXT_CNT_OFF && pwdata[15:0] != 16'h0000 && !rx_step
        |=> !rx_buffers_full_flag && !rx_end_flag)
        else $error("rx flags not cleared by count write");

    tx_load_a: assert property ( // see RL15
        r.state == ST_TX_RD && bus_ack
        |=> tx_holding_load && tx_holding_reg == $past(bus_rdata) ##1 !tx_holding_load)
        else $error("tx holding load missing after fetch");

    tx_end_a: assert property ( // see RL11
        tx_step && tx_set.cur_cnt == 16'h0001 && !wr_en
        |=> tx_end_flag && tx_holding_load)
        else $error("tx end flag not set with last load");

    tx_empty_a: assert property ( // see RL13
        tx_step && tx_set.cur_cnt == 16'h0001 && tx_set.nxt_cnt == 16'h0000 && !wr_en
        |=> tx_buffers_empty_flag)
        else $error("tx empty flag not set");

    tx_chain_a: assert property ( // see RL9
        tx_step && tx_set.cur_cnt == 16'h0001 && tx_set.nxt_cnt != 16'h0000 && !wr_en
        |=> !tx_buffers_empty_flag || $past(tx_buffers_empty_flag))
        else $error("tx empty flag raised while chaining");

    irq_level_a: assert property (
        (|(irq_status & irq_mask)) |-> irq)
        else $error("interrupt low with unmasked status");
endmodule

// file: verif/pdu_mem_model.sv
// bus matrix and memory model: grants, answers after a settable wait
`timescale 1ns/1ns
module pdu_mem_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic bus_req,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    output logic bus_gnt,
    output logic bus_ack,
    output logic [31:0] bus_rdata,
    output logic [31:0] last_addr,
    output logic [31:0] last_data
);
    logic [3:0] wt;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_gnt <= 1'b0;
            bus_ack <= 1'b0;
            wt <= 4'h0;
            bus_rdata <= 32'h0;
            last_addr <= 32'h0;
            last_data <= 32'h0;
        end else begin
            bus_ack <= 1'b0;
            bus_gnt <= bus_req && !bus_ack;
            bus_rdata <= ~bus_rdata;
            if (bus_req && bus_gnt && !bus_ack) begin
                wt <= wt + 4'h1;
                if (wt == (slow ? 4'h5 : 4'h2)) begin
                    wt <= 4'h0;
                    bus_ack <= 1'b1;
                    bus_rdata <= bus_addr ^ 32'ha5a5_0000;
                    if (bus_write) begin
                        last_addr <= bus_addr;
                        last_data <= bus_wdata;
                    end
                end
            end
        end
    end
endmodule

// file: verif/pdu_top_bench.sv
// register and transfer tests of the peripheral dma unit
`timescale 1ns/1ns
module pdu_top_bench;
    import pdu_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic rx_ready = 1'b0;
    logic tx_ready = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rx_holding_reg = 32'h0;
    logic [31:0] prdata, tx_holding_reg, bus_addr, bus_wdata, bus_rdata, last_addr, last_data, q;
    logic pready, pslverr, rx_holding_read, tx_holding_load, bus_req, bus_gnt, bus_write;
    logic rx_end_flag, tx_end_flag, rx_buffers_full_flag, tx_buffers_empty_flag, bus_ack;
    logic rx_channel_enabled, tx_channel_enabled, irq, err;
    pdu_size_type bus_size;
    int n_errors = 0;
    int checks_done = 0;
    int i;
    always #10 clk = ~clk;
    pdu_top pdu_top_i (.clk, .reset_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .rx_ready, .rx_holding_reg, .rx_holding_read, .tx_ready,
        .tx_holding_reg, .tx_holding_load, .rx_end_flag, .tx_end_flag, .rx_buffers_full_flag,
        .tx_buffers_empty_flag, .rx_channel_enabled, .tx_channel_enabled, .bus_req, .bus_gnt,
        .bus_addr, .bus_write, .bus_size, .bus_wdata, .bus_rdata, .bus_ack, .irq);
    pdu_mem_model pdu_mem_model_i (.clk, .reset_n, .slow, .bus_req, .bus_write, .bus_addr,
        .bus_wdata, .bus_gnt, .bus_ack, .bus_rdata, .last_addr, .last_data);
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // peripheral side: offer one item, drop ready once it is taken
    task automatic rx_item(input logic [31:0] d, input logic [31:0] a);
        rx_ready <= 1'b1;
        rx_holding_reg <= d;
        for (i = 0; i < 40 && rx_holding_read !== 1'b1; i++) @(posedge clk);
        rx_ready <= 1'b0;
        rx_holding_reg <= ~d;
        @(posedge clk);
        for (i = 0; i < 40 && bus_req !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        chk(last_addr, a);
        chk(last_data, d);
    endtask
    // peripheral side: ask for one item, drop ready once the fetch starts
    task automatic tx_item(input logic [31:0] exp);
        tx_ready <= 1'b1;
        for (i = 0; i < 40 && bus_req !== 1'b1; i++) @(posedge clk);
        tx_ready <= 1'b0;
        for (i = 0; i < 40 && tx_holding_load !== 1'b1; i++) @(posedge clk);
        chk(tx_holding_reg, exp);
        repeat (2) @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(RX_CUR_CNT_OFF, 32'h0);
        rd(STAT_OFF, 32'h0);
        rd(12'h200, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(CONFIG_OFF, 32'h2);
        chk({30'h0, bus_size}, 32'h2);
        wr(RX_CUR_PTR_OFF, 32'h2000);
        wr(RX_CUR_CNT_OFF, 32'h2);
        wr(RX_NXT_PTR_OFF, 32'h3000);
        wr(RX_NXT_CNT_OFF, 32'h1);
        rd(RX_NXT_PTR_OFF, 32'h3000);
        wr(CTRL_OFF, 32'h1);
        rd(STAT_OFF, 32'h1);
        rx_item(32'hc0de0001, 32'h2000);
        rd(RX_CUR_CNT_OFF, 32'h1);
        rd(RX_CUR_PTR_OFF, 32'h2004);
        wr(RX_CUR_PTR_OFF, 32'h2100);
        slow <= 1'b1;
        rx_item(32'hc0de0002, 32'h2100);
        chk({30'h0, rx_end_flag, rx_buffers_full_flag}, 32'h2);
        rd(RX_CUR_PTR_OFF, 32'h3000);
        rd(RX_NXT_CNT_OFF, 32'h0);
        rx_item(32'hc0de0003, 32'h3000);
        chk({30'h0, rx_end_flag, rx_buffers_full_flag}, 32'h3);
        rx_ready <= 1'b1;
        repeat (6) @(posedge clk);
        chk({31'h0, bus_req}, 32'h0);
        rx_ready <= 1'b0;
        wr(CTRL_OFF, 32'h2);
        rd(STAT_OFF, 32'h0);
        wr(RX_NXT_CNT_OFF, 32'h1);
        chk({30'h0, rx_end_flag, rx_buffers_full_flag}, 32'h0);
        wr(CONFIG_OFF, 32'h0);
        wr(TX_CUR_PTR_OFF, 32'h10);
        wr(TX_CUR_CNT_OFF, 32'h1);
        wr(TX_NXT_PTR_OFF, 32'h20);
        wr(TX_NXT_CNT_OFF, 32'h1);
        wr(CTRL_OFF, 32'h100);
        rd(STAT_OFF, 32'h100);
        tx_item(32'ha5a5_0010);
        chk({30'h0, tx_end_flag, tx_buffers_empty_flag}, 32'h2);
        rd(TX_CUR_PTR_OFF, 32'h20);
        rd(TX_NXT_CNT_OFF, 32'h0);
        tx_item(32'ha5a5_0020);
        chk({30'h0, tx_end_flag, tx_buffers_empty_flag}, 32'h3);
        rd(TX_CUR_PTR_OFF, 32'h21);
        chk({31'h0, irq}, 32'h0);
        rd(IRQ_STAT_OFF, 32'hf);
        wr(IRQ_MASK_OFF, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_OFF, 32'hf);
        chk({31'h0, irq}, 32'h0);
        rd(IRQ_STAT_OFF, 32'h0);
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        report_and_stop;
    end
endmodule
